// file: logic/pd_cfg_pkg.sv
package pd_cfg_pkg;

   // ****************************************
   // register map and widths
   // ****************************************
   localparam int          REG_W          = 24;
   localparam int          ADDR_W         = 6;
   localparam int          FRAME_BITS     = 31;
   localparam logic [5:0]  REF_DIV_ADDR   = 6'h02;
   localparam logic [5:0]  FB_INT_ADDR    = 6'h03;
   localparam logic [5:0]  FB_FRAC_ADDR   = 6'h04;
   localparam logic [5:0]  PD_CTRL_ADDR   = 6'h0b;
   localparam logic [5:0]  OUT_DIV_ADDR   = 6'h10;
   localparam logic [5:0]  STATUS_ADDR    = 6'h11;

   // ****************************************
   // phase detector control fields
   // ****************************************
   localparam int          DEL_SEL_LSB    = 0;
   localparam int          UP_EN_BIT      = 5;
   localparam int          DN_EN_BIT      = 6;
   localparam int          SLIP_LSB       = 7;
   localparam int          PUMP_UP_BIT    = 9;
   localparam int          PUMP_DN_BIT    = 10;
   localparam logic [23:0] PD_CTRL_RST    = 24'h0f8061;

   // ****************************************
   // divider limits and resets
   // ****************************************
   localparam int          FRAC_W         = 24;
   localparam int          FB_INT_W       = 20;
   localparam logic [19:0] FB_INT_MIN     = 20'h00010;
   localparam logic [19:0] FB_INT_MAX     = 20'h803e7;
   localparam logic [19:0] FB_FRAC_MIN    = 20'h00014;
   localparam logic [19:0] FB_FRAC_MAX    = 20'h3b26c;
   localparam logic [23:0] REF_DIV_RST    = 24'h000001;
   localparam logic [23:0] FB_INT_RST     = 24'h000010;
   localparam logic [23:0] FB_FRAC_RST    = 24'h000000;
   localparam logic [23:0] OUT_DIV_RST    = 24'h000002;
   localparam int          REF_IN_MAX_MHZ = 350;
   localparam int          CMP_MAX_MHZ    = 100;

   // ****************************************
   // slip prevention thresholds
   // ****************************************
   localparam real         CLK_NS         = 20.0;
   localparam real         SLIP1_NS       = 5.4;
   localparam real         SLIP2_NS       = 14.4;
   localparam real         SLIP3_NS       = 24.1;
   localparam int          SLIP1_CYC      = (SLIP1_NS < CLK_NS) ? 1 : int'(SLIP1_NS / CLK_NS - 0.5);
   localparam int          SLIP2_CYC      = (SLIP2_NS < CLK_NS) ? 1 : int'(SLIP2_NS / CLK_NS - 0.5);
   localparam int          SLIP3_CYC      = (SLIP3_NS < CLK_NS) ? 1 : int'(SLIP3_NS / CLK_NS - 0.5);

   typedef enum logic [1:0] {SLIP_OFF, SLIP_LOW, SLIP_MID, SLIP_HIGH} slip_e;

endpackage

// file: logic/serial_reg_port.sv
`timescale 1ns/100ps
module serial_reg_port
   import pd_cfg_pkg::*;
(
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   input  wire logic                        sclk_i,
   input  wire logic                        sen_i,
   input  wire logic                        sdi_i,
   input  wire logic [pd_cfg_pkg::REG_W-1:0] rdata_i,
   output logic                             sdo_o,
   output logic                             sdo_oe_o,
   output logic                             wr_o,
   output logic [pd_cfg_pkg::ADDR_W-1:0]    addr_o,
   output logic [pd_cfg_pkg::REG_W-1:0]     wdata_o
);
   import pd_cfg_pkg::*;

   // ****************************************
   // frame shifter: rw, 6 address bits, 24 data bits, msb first
   // ****************************************
   logic [FRAME_BITS-1:0] sh_r,   sh_nxt;
   logic [4:0]            cnt_r,  cnt_nxt;
   logic                  sclk_r, sen_r;
   logic [REG_W-1:0]      out_r,  out_nxt;
   logic                  oe_r,   oe_nxt;
   logic                  wr_r,   wr_nxt;
   logic                  rise, fall;

   always_comb
   begin
      rise    = sen_i && sclk_i && !sclk_r;
      fall    = sen_i && !sclk_i && sclk_r;
      sh_nxt  = sh_r;
      cnt_nxt = cnt_r;
      out_nxt = out_r;
      oe_nxt  = oe_r;
      wr_nxt  = 1'b0;
      if (!sen_i)
      begin
         cnt_nxt = 5'h00;
         oe_nxt  = 1'b0;
         // a short or read frame never writes
         wr_nxt  = sen_r && (cnt_r == 5'(FRAME_BITS)) && !sh_r[FRAME_BITS-1];
      end
      else if (rise && cnt_r != 5'(FRAME_BITS))
      begin
         sh_nxt  = {sh_r[FRAME_BITS-2:0], sdi_i};
         cnt_nxt = cnt_r + 5'h01;
      end
      else if (fall && cnt_r == 5'(ADDR_W + 1) && sh_r[ADDR_W])
      begin
         out_nxt = rdata_i;
         oe_nxt  = 1'b1;
      end
      else if (fall && oe_r)
         out_nxt = {out_r[REG_W-2:0], 1'b0};
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sh_r   <= '0;
         cnt_r  <= 5'h00;
         out_r  <= '0;
         oe_r   <= 1'b0;
         wr_r   <= 1'b0;
         sclk_r <= 1'b0;
         sen_r  <= 1'b0;
      end
      else
      begin
         sh_r   <= sh_nxt;
         cnt_r  <= cnt_nxt;
         out_r  <= out_nxt;
         oe_r   <= oe_nxt;
         wr_r   <= wr_nxt;
         sclk_r <= sclk_i;
         sen_r  <= sen_i;
      end
   end

   // address bits sit in the low part while reading, high part once the frame is full
   // the count clears with the strobe, so the strobe itself keeps the high part selected
   assign addr_o   = ((cnt_r == 5'(FRAME_BITS)) || wr_r) ? sh_r[FRAME_BITS-2 -: ADDR_W] : sh_r[ADDR_W-1:0];
   assign wdata_o  = sh_r[REG_W-1:0];
   assign wr_o     = wr_r;
   assign sdo_o    = out_r[REG_W-1];
   assign sdo_oe_o = oe_r;

endmodule

// file: logic/pll_phase_detector_divider_config.sv
`timescale 1ns/100ps
// Overview of operation
// - bits [2:0] of the phase detector control register select the detector reset path delay, default one.
// - bit 5 enables the detector up output and resets to one.
// - bit 6 enables the detector down output and resets to one.
// - bits [8:7] select slip prevention off or a 5.4, 14.4 or 24.1 ns phase error threshold.
// - bit 9 forces the pump up output on for test and resets to zero.
// - bit 10 forces the pump down output on for test and resets to zero.
// - the reference divider takes up to 350 MHz and divides it to keep comparison below 100 MHz.
// - the feedback ratio is an integer register plus a fraction in the next register.
// - output over input frequency equals feedback ratio over reference ratio times output ratio.
// - the fraction is a 24-bit value in units of two to the minus twenty-fourth.
module pll_phase_detector_divider_config
   import pd_cfg_pkg::*;
#(
   parameter int REF_DIV_W = 14,
   parameter int OUT_DIV_W = 8
)
(
   input  wire logic                           sys_clk_i,
   input  wire logic                           rst_n_i,
   input  wire logic                           sclk_i,
   input  wire logic                           sen_i,
   input  wire logic                           sdi_i,
   output logic                                sdo_o,
   output logic                                sdo_oe_o,
   output logic [2:0]                          detector_reset_delay_select_o,
   output logic                                detector_up_output_enable_o,
   output logic                                detector_down_output_enable_o,
   output pd_cfg_pkg::slip_e                   slip_prevention_threshold_o,
   output logic [7:0]                          slip_threshold_cycles_o,
   output logic                                pump_up_force_on_o,
   output logic                                pump_down_force_on_o,
   output logic [REF_DIV_W-1:0]                reference_divide_ratio_o,
   output logic [pd_cfg_pkg::FB_INT_W+pd_cfg_pkg::FRAC_W-1:0] feedback_divide_ratio_o,
   output logic [OUT_DIV_W-1:0]                output_divide_ratio_o,
   output logic [REF_DIV_W+OUT_DIV_W-1:0]      gear_denominator_o,
   output logic                                feedback_range_error_o,
   output logic                                output_ratio_odd_o
);
   import pd_cfg_pkg::*;

   // ****************************************
   // reset release
   // ****************************************
   logic rst_s1_r, rst_s2_r, rst_n;

   always_ff @(posedge sys_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   assign rst_n = rst_s2_r;

   // ****************************************
   // serial port
   // ****************************************
   logic              wr;
   logic [ADDR_W-1:0] addr;
   logic [REG_W-1:0]  wdata;
   logic [REG_W-1:0]  rdata_r, rdata_nxt;

   serial_reg_port u_port
   (
      .clk_i    (sys_clk_i),
      .rst_n_i  (rst_n),
      .sclk_i   (sclk_i),
      .sen_i    (sen_i),
      .sdi_i    (sdi_i),
      .rdata_i  (rdata_r),
      .sdo_o    (sdo_o),
      .sdo_oe_o (sdo_oe_o),
      .wr_o     (wr),
      .addr_o   (addr),
      .wdata_o  (wdata)
   );

   // ****************************************
   // register bank
   // ****************************************
   logic [REG_W-1:0] pd_r,   pd_nxt;
   logic [REG_W-1:0] ref_r,  ref_nxt;
   logic [REG_W-1:0] fbi_r,  fbi_nxt;
   logic [REG_W-1:0] fbf_r,  fbf_nxt;
   logic [REG_W-1:0] outd_r, outd_nxt;
   logic [7:0]       thr_nxt;
   logic             rng_err_nxt;

   localparam int SLIP_LOW_BIT = SLIP_LSB + 1;

   function automatic logic [7:0] slip_cycles(input logic [1:0] code);
      case (code)
         2'h1:    slip_cycles = 8'(SLIP1_CYC);
         2'h2:    slip_cycles = 8'(SLIP2_CYC);
         2'h3:    slip_cycles = 8'(SLIP3_CYC);
         default: slip_cycles = 8'h00;
      endcase
   endfunction

   always_comb
   begin
      pd_nxt   = pd_r;
      ref_nxt  = ref_r;
      fbi_nxt  = fbi_r;
      fbf_nxt  = fbf_r;
      outd_nxt = outd_r;
      if (wr)
      begin
         case (addr)
            PD_CTRL_ADDR: pd_nxt   = wdata;
            REF_DIV_ADDR: ref_nxt  = wdata;
            FB_INT_ADDR:  fbi_nxt  = wdata;
            FB_FRAC_ADDR: fbf_nxt  = wdata;
            OUT_DIV_ADDR: outd_nxt = wdata;
            default:      pd_nxt   = pd_r;
         endcase
      end
      case (addr)
         PD_CTRL_ADDR: rdata_nxt = pd_r;
         REF_DIV_ADDR: rdata_nxt = ref_r;
         FB_INT_ADDR:  rdata_nxt = fbi_r;
         FB_FRAC_ADDR: rdata_nxt = fbf_r;
         OUT_DIV_ADDR: rdata_nxt = outd_r;
         STATUS_ADDR:  rdata_nxt = {22'h000000, output_ratio_odd_o, feedback_range_error_o};
         default:      rdata_nxt = '0;
      endcase
      thr_nxt = slip_cycles(pd_r[SLIP_LOW_BIT:SLIP_LSB]);
      // fraction zero means integer mode; the limits differ by mode
      if (fbf_r == '0)
         rng_err_nxt = (fbi_r[FB_INT_W-1:0] < FB_INT_MIN) || (fbi_r[FB_INT_W-1:0] > FB_INT_MAX)
                       || (fbi_r[REG_W-1:FB_INT_W] != '0);
      else
         rng_err_nxt = (fbi_r[FB_INT_W-1:0] < FB_FRAC_MIN) || (fbi_r[FB_INT_W-1:0] >= FB_FRAC_MAX)
                       || (fbi_r[REG_W-1:FB_INT_W] != '0);
   end

   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pd_r    <= PD_CTRL_RST;
         ref_r   <= REF_DIV_RST;
         fbi_r   <= FB_INT_RST;
         fbf_r   <= FB_FRAC_RST;
         outd_r  <= OUT_DIV_RST;
         rdata_r <= '0;
         slip_threshold_cycles_o <= 8'h00;
         feedback_range_error_o  <= 1'b0;
      end
      else
      begin
         pd_r    <= pd_nxt;
         ref_r   <= ref_nxt;
         fbi_r   <= fbi_nxt;
         fbf_r   <= fbf_nxt;
         outd_r  <= outd_nxt;
         rdata_r <= rdata_nxt;
         slip_threshold_cycles_o <= thr_nxt;
         feedback_range_error_o  <= rng_err_nxt;
      end
   end

   // ****************************************
   // field outputs, registered copies plus the registered gear product
   // ****************************************
   always_ff @(posedge sys_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         detector_reset_delay_select_o <= PD_CTRL_RST[DEL_SEL_LSB +: 3];
         detector_up_output_enable_o   <= PD_CTRL_RST[UP_EN_BIT];
         detector_down_output_enable_o <= PD_CTRL_RST[DN_EN_BIT];
         slip_prevention_threshold_o   <= SLIP_OFF;
         pump_up_force_on_o            <= PD_CTRL_RST[PUMP_UP_BIT];
         pump_down_force_on_o          <= PD_CTRL_RST[PUMP_DN_BIT];
         reference_divide_ratio_o      <= REF_DIV_RST[REF_DIV_W-1:0];
         feedback_divide_ratio_o       <= {FB_INT_RST[FB_INT_W-1:0], FB_FRAC_RST};
         output_divide_ratio_o         <= OUT_DIV_RST[OUT_DIV_W-1:0];
         gear_denominator_o            <= '0;
         output_ratio_odd_o            <= 1'b0;
      end
      else
      begin
         detector_reset_delay_select_o <= pd_r[DEL_SEL_LSB +: 3];
         detector_up_output_enable_o   <= pd_r[UP_EN_BIT];
         detector_down_output_enable_o <= pd_r[DN_EN_BIT];
         slip_prevention_threshold_o   <= slip_e'(pd_r[SLIP_LOW_BIT:SLIP_LSB]);
         pump_up_force_on_o            <= pd_r[PUMP_UP_BIT];
         pump_down_force_on_o          <= pd_r[PUMP_DN_BIT];
         reference_divide_ratio_o      <= ref_r[REF_DIV_W-1:0];
         feedback_divide_ratio_o       <= {fbi_r[FB_INT_W-1:0], fbf_r[FRAC_W-1:0]};
         output_divide_ratio_o         <= outd_r[OUT_DIV_W-1:0];
         // product is the ratio denominator; numerator is the feedback ratio
         gear_denominator_o            <= ref_r[REF_DIV_W-1:0] * outd_r[OUT_DIV_W-1:0];
         output_ratio_odd_o            <= outd_r[0];
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_del_sel;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr && addr == PD_CTRL_ADDR) |-> ##2 detector_reset_delay_select_o == $past(wdata[2:0], 2);
   endproperty
   a_del_sel: assert property (p_del_sel) else $error("delay select not updated");

   property p_up_en;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr && addr == PD_CTRL_ADDR) |-> ##2 detector_up_output_enable_o == $past(wdata[UP_EN_BIT], 2);
   endproperty
   a_up_en: assert property (p_up_en) else $error("up enable mismatch");

   property p_dn_en;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr && addr == PD_CTRL_ADDR) |-> ##2 detector_down_output_enable_o == $past(wdata[DN_EN_BIT], 2);
   endproperty
   a_dn_en: assert property (p_dn_en) else $error("down enable not updated");

   property p_slip;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (pd_r[SLIP_LOW_BIT:SLIP_LSB] == 2'h0) [*2] |-> slip_threshold_cycles_o == 8'h00;
   endproperty
   a_slip: assert property (p_slip) else $error("slip threshold active while off");

   property p_pump_up;
      @(posedge sys_clk_i) disable iff (!rst_n)
      $rose(pd_r[PUMP_UP_BIT]) |=> pump_up_force_on_o;
   endproperty
   a_pump_up: assert property (p_pump_up) else $error("pump up force lost");

   property p_pump_dn;
      @(posedge sys_clk_i) disable iff (!rst_n)
      $fell(pd_r[PUMP_DN_BIT]) |=> !pump_down_force_on_o;
   endproperty
   a_pump_dn: assert property (p_pump_dn) else $error("pump down force stuck");

   property p_fb_ratio;
      @(posedge sys_clk_i) disable iff (!rst_n)
      (wr && addr == FB_FRAC_ADDR) |-> ##2 feedback_divide_ratio_o[FRAC_W-1:0] == $past(wdata, 2);
   endproperty
   a_fb_ratio: assert property (p_fb_ratio) else $error("fraction not applied");

   property p_gear;
      @(posedge sys_clk_i) disable iff (!rst_n)
      // reset value is zero, not the product, so skip the edge of release
      rst_n && $stable(ref_r) && $stable(outd_r) |=>
         gear_denominator_o == 22'($past(ref_r[REF_DIV_W-1:0])) * 22'($past(outd_r[OUT_DIV_W-1:0]));
   endproperty
   a_gear: assert property (p_gear) else $error("gear denominator wrong");

endmodule

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
   import pd_cfg_pkg::*;

   // ****************************************
   // stimulus and observed signals
   // ****************************************
   logic         sys_clk_i = 1'b0;
   logic         rst_n_i   = 1'b0;
   logic         sclk_i    = 1'b0;
   logic         sen_i     = 1'b0;
   logic         sdi_i     = 1'b0;
   logic         sdo;
   logic         oe;
   logic [2:0]   dly;
   logic         up_en;
   logic         dn_en;
   slip_e        slip;
   logic [7:0]   slip_cyc;
   logic         pu;
   logic         pd;
   logic [13:0]  refd;
   logic [43:0]  fbd;
   logic [7:0]   outd;
   logic [21:0]  gear;
   logic         rerr;
   logic         odd;
   int           num_errors  = 0;
   int           checks_done = 0;
   logic [31:0]  seed        = 32'h7307;
   logic [23:0]  regs [0:63];
   int           slip_tab [4];
   int           ints [8]    = '{15, 16, 525287, 525288, 19, 20, 242283, 242284};

   always #10 sys_clk_i = ~sys_clk_i;

   pll_phase_detector_divider_config #(.REF_DIV_W(14), .OUT_DIV_W(8)) dut_u
   (
      .sys_clk_i                     (sys_clk_i),
      .rst_n_i                       (rst_n_i),
      .sclk_i                        (sclk_i),
      .sen_i                         (sen_i),
      .sdi_i                         (sdi_i),
      .sdo_o                         (sdo),
      .sdo_oe_o                      (oe),
      .detector_reset_delay_select_o (dly),
      .detector_up_output_enable_o   (up_en),
      .detector_down_output_enable_o (dn_en),
      .slip_prevention_threshold_o   (slip),
      .slip_threshold_cycles_o       (slip_cyc),
      .pump_up_force_on_o            (pu),
      .pump_down_force_on_o          (pd),
      .reference_divide_ratio_o      (refd),
      .feedback_divide_ratio_o       (fbd),
      .output_divide_ratio_o         (outd),
      .gear_denominator_o            (gear),
      .feedback_range_error_o        (rerr),
      .output_ratio_odd_o            (odd)
   );

   // ****************************************
   // reference model
   // ****************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic mapped(input logic [5:0] a);
      return a inside {REF_DIV_ADDR, FB_INT_ADDR, FB_FRAC_ADDR, PD_CTRL_ADDR, OUT_DIV_ADDR};
   endfunction

   // zero fraction means integer mode
   function automatic logic rng_err();
      logic [23:0] n;
      n = regs[FB_INT_ADDR];
      if (regs[FB_FRAC_ADDR] == 24'h000000)
         return (n < FB_INT_MIN) || (n > FB_INT_MAX);
      return (n < FB_FRAC_MIN) || (n >= FB_FRAC_MAX);
   endfunction

   function automatic logic [23:0] rd_model(input logic [5:0] a);
      if (mapped(a))
         return regs[a];
      if (a == STATUS_ADDR)
         return {22'h000000, regs[OUT_DIV_ADDR][0], rng_err()};
      return 24'h000000;
   endfunction

   task automatic model_reset();
      foreach (regs[i])
         regs[i] = 24'h000000;
      regs[PD_CTRL_ADDR] = PD_CTRL_RST;
      regs[REF_DIV_ADDR] = REF_DIV_RST;
      regs[FB_INT_ADDR]  = FB_INT_RST;
      regs[FB_FRAC_ADDR] = FB_FRAC_RST;
      regs[OUT_DIV_ADDR] = OUT_DIV_RST;
   endtask

   // ****************************************
   // checking and reporting
   // ****************************************
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_all();
      logic [23:0] p;
      // sample away from the launching edge
      @(negedge sys_clk_i);
      p = regs[PD_CTRL_ADDR];
      chk(dly, p[2:0]);
      chk(up_en, p[5]);
      chk(dn_en, p[6]);
      chk(slip, p[8:7]);
      chk(slip_cyc, slip_tab[p[8:7]]);
      chk(pu, p[9]);
      chk(pd, p[10]);
      chk(refd, regs[REF_DIV_ADDR][13:0]);
      chk(fbd, {regs[FB_INT_ADDR][19:0], regs[FB_FRAC_ADDR]});
      chk(outd, regs[OUT_DIV_ADDR][7:0]);
      chk(gear, regs[REF_DIV_ADDR][13:0] * regs[OUT_DIV_ADDR][7:0]);
      chk(rerr, rng_err());
      chk(odd, regs[OUT_DIV_ADDR][0]);
   endtask

   task automatic done(input string name);
      $display("test %s finished, errors so far %0d", name, num_errors);
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ****************************************
   // serial port driver
   // ****************************************
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   // slow sclk: high level held four system cycles, low level five
   task automatic frame(input logic rw, input logic [5:0] a, input logic [23:0] d, input int nb);
      logic [30:0] sh;
      logic [23:0] got;
      sh = {rw, a, d};
      got = 24'h000000;
      @(posedge sys_clk_i);
      sen_i <= 1'b1;
      cyc(4);
      for (int i = 0; i < nb; i++)
      begin
         sdi_i <= sh[30-i];
         cyc(4);
         @(negedge sys_clk_i);
         if (i > 6)
            got = {got[22:0], sdo};
         if (i == 7)
            chk(oe, rw);
         @(posedge sys_clk_i);
         sclk_i <= 1'b1;
         cyc(4);
         sclk_i <= 1'b0;
      end
      cyc(4);
      sen_i <= 1'b0;
      cyc(4);
      if (!rw && nb == 31 && mapped(a))
         regs[a] = d;
      if (rw && nb == 31)
         chk(got, rd_model(a));
   endtask

   task automatic do_reset(input int n);
      @(posedge sys_clk_i);
      rst_n_i <= 1'b0;
      cyc(n);
      rst_n_i <= 1'b1;
      model_reset();
      cyc(5);
   endtask

   // ****************************************
   // test sequence
   // ****************************************
   initial
   begin
      logic [23:0] v;
      slip_tab = '{0, SLIP1_CYC, SLIP2_CYC, SLIP3_CYC};
      do_reset(6);
      check_all();
      frame(1'b1, PD_CTRL_ADDR, 24'h000000, 31);
      done("reset");
      // reserved bits kept at default, only live fields randomised
      for (int k = 0; k < 8; k++)
      begin
         seed = lfsr(seed);
         v = (seed[23:0] & 24'h0007e7) | (PD_CTRL_RST & ~24'h0007e7);
         v[8:7] = k[1:0];
         frame(1'b0, PD_CTRL_ADDR, v, 31);
         check_all();
         frame(1'b1, PD_CTRL_ADDR, 24'h000000, 31);
      end
      done("pd control");
      for (int k = 0; k < 8; k++)
      begin
         seed = lfsr(seed);
         frame(1'b0, REF_DIV_ADDR, {10'h000, seed[13:0]}, 31);
         frame(1'b0, OUT_DIV_ADDR, {16'h0000, seed[21:14]}, 31);
         frame(1'b0, FB_FRAC_ADDR, (k < 4) ? 24'h000000 : (seed[23:0] | 24'h000001), 31);
         frame(1'b0, FB_INT_ADDR, 24'(ints[k]), 31);
         check_all();
         frame(1'b1, STATUS_ADDR, 24'h000000, 31);
         frame(1'b1, FB_FRAC_ADDR, 24'h000000, 31);
      end
      done("dividers");
      frame(1'b0, PD_CTRL_ADDR, 24'h000000, 30);
      check_all();
      frame(1'b0, 6'h20, 24'h5a5a5a, 31);
      frame(1'b1, 6'h20, 24'h000000, 31);
      check_all();
      done("refused");
      do_reset(3);
      check_all();
      frame(1'b1, PD_CTRL_ADDR, 24'h000000, 31);
      done("mid reset");
      stop_test();
   end

   // about 20k cycles expected, so 60k is a safe ceiling
   initial
   begin
      cyc(60000);
      num_errors++;
      $display("watchdog expired at t=%0t", $time);
      stop_test();
   end

endmodule
